// File: hdl/lsi_defs.svh
// timing constants and register map of the status indicator block
// assumes a 125 MHz device clock and word-aligned AHB-Lite register access
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH
`define LSI_CLK_HZ 125000000
`define LSI_FLASH_HZ 10
// half period of the flash waveform, in clock cycles
`define LSI_HALF_CYCLES (`LSI_CLK_HZ / (2 * `LSI_FLASH_HZ))
`define LSI_OFF_STATUS 32'h0000_0000
`define LSI_OFF_MASK 32'h0000_0004
`define LSI_OFF_STATE 32'h0000_0008
`define LSI_OFF_CTRL 32'h0000_000c
`define LSI_EV_W 4
`define LSI_CTRL_RST 1'b1
`endif

// File: hdl/lsi_pkg.sv
// types shared by the status indicator block
// assumes lsi_defs.svh is on the include path
`default_nettype none
package lsi_pkg;
  // activity detector inputs of one port
  typedef struct packed {
    logic tx;
    logic rx;
    logic col;
  } lsi_act_t;
  // ahb-lite slave request
  typedef struct packed {
    logic sel;
    logic [1:0] trans;
    logic [31:0] addr;
    logic write;
    logic [2:0] size;
    logic ready;
  } lsi_ahb_req_t;
endpackage : lsi_pkg
`default_nettype wire

// File: hdl/lsi_sync.sv
// two flip-flop synchroniser for a vector of pin levels
// assumes inputs are asynchronous to i_clk
`default_nettype none
module lsi_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_ce,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lsi_sync_st_t;
  lsi_sync_st_t st_ff;
  lsi_sync_st_t nxt_st;
  // first stage is read only by the second
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.s1 = i_d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_ce)
      st_ff <= nxt_st;
  end
  assign o_q = st_ff.s2;
endmodule : lsi_sync
`default_nettype wire

// File: hdl/lsi_flash.sv
// shared 10 Hz flash phase generator
// assumes i_ce freezes the count
`include "lsi_defs.svh"
`default_nettype none
module lsi_flash #(
  parameter int HALF = `LSI_HALF_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  output logic o_phase
);
  import lsi_pkg::*;
  typedef struct packed {
    logic [31:0] cnt;
    logic ph;
  } lsi_flash_st_t;
  lsi_flash_st_t st_ff;
  lsi_flash_st_t nxt_st;
  initial
  begin
    if (HALF < 1)
      $error("flash half period must be at least one cycle");
  end
  always_comb
  begin
    nxt_st = st_ff;
    if (st_ff.cnt == 32'(HALF - 1))
    begin
      nxt_st.cnt = 32'h0;
      nxt_st.ph = ~st_ff.ph;
    end
    else
      nxt_st.cnt = st_ff.cnt + 32'h1;
  end
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      st_ff <= '0;
    else if (i_ce)
      st_ff <= nxt_st;
  end
  assign o_phase = st_ff.ph;
endmodule : lsi_flash
`default_nettype wire

// File: hdl/lsi_top.sv
// status indicator logic: activity leds, twisted pair flags, ahb-lite status
// assumes detector inputs are asynchronous pins; bus is on i_clk
`include "lsi_defs.svh"
`default_nettype none
module lsi_top #(
  parameter int HALF_CYCLES = `LSI_HALF_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire lsi_pkg::lsi_act_t i_pair_act,
  input wire lsi_pkg::lsi_act_t i_aui_act,
  input wire logic i_pair_selected,
  input wire logic i_link_ok,
  input wire logic i_pair_rx_reversed,
  input wire logic i_jabber,
  input wire logic i_polarity_correct_enable,
  input wire logic i_ctrl_select_0,
  input wire logic i_ctrl_select_1,
  input wire logic i_ctrl_select_2,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic o_tx_activity_led_n,
  output logic o_tx_activity_led_n_oe,
  output logic o_rx_activity_led_n,
  output logic o_rx_activity_led_n_oe,
  output logic o_collision_led_n,
  output logic o_collision_led_n_oe,
  output logic o_link_good_n,
  output logic o_link_good_n_oe,
  output logic o_polarity_fault_n,
  output logic o_polarity_fault_n_oe,
  output logic o_jabber_flag,
  output logic o_jabber_flag_oe,
  output logic o_polarity_correct_active,
  output logic o_irq
);
  import lsi_pkg::*;

  // two activity structs plus eight single levels
  localparam int NS = 14;

  typedef struct packed {
    logic [`LSI_EV_W-1:0] status;
    logic [`LSI_EV_W-1:0] mask;
    logic ctrl_en;
    logic [`LSI_EV_W-1:0] prev;
    logic dp_write;
    logic dp_read;
    logic [3:0] dp_addr;
    logic [31:0] rdata;
    logic tx_led;
    logic rx_led;
    logic col_led;
    logic link_n;
    logic pol_n;
    logic jab;
    logic oe_all;
    logic oe_pair;
  } lsi_top_st_t;

  lsi_top_st_t st_ff;
  lsi_top_st_t nxt_st;
  logic [NS-1:0] raw_pins;
  logic [NS-1:0] sy;
  logic phase;
  lsi_act_t act;
  logic standby;
  logic pair_sel;
  logic link_ok;
  logic rev;
  logic jab;
  logic pce;
  logic [`LSI_EV_W-1:0] ev;

  initial
  begin
    if (HALF_CYCLES < 1)
      $error("HALF_CYCLES must be at least one");
  end

  // pin inputs cross into the clock domain before use
  assign raw_pins = {i_pair_act, i_aui_act, i_pair_selected, i_link_ok,
                     i_pair_rx_reversed, i_jabber, i_polarity_correct_enable,
                     i_ctrl_select_0, i_ctrl_select_1, i_ctrl_select_2};

  lsi_sync #(
    .W(NS)
  ) u_sync (
    .i_clk(i_clk),
    .i_ce(i_ce),
    .i_d(raw_pins),
    .o_q(sy)
  );

  lsi_flash #(
    .HALF(HALF_CYCLES)
  ) u_flash (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .o_phase(phase)
  );

  // unpack synchronised levels
  assign pair_sel = sy[7];
  assign link_ok = sy[6];
  assign rev = sy[5];
  assign jab = sy[4];
  assign pce = sy[3];
  assign standby = &sy[2:0] ? 1'b1 : 1'b0;
  assign act = pair_sel ? lsi_act_t'(sy[13:11]) : lsi_act_t'(sy[10:8]);
  // events: link lost, polarity fault, jabber, standby entry
  assign ev = {standby, jab & pair_sel, pce & rev & pair_sel, ~link_ok & pair_sel};

  // led driver: low on phase while active, resting high (off)
  function automatic logic led_level(input logic active, input logic ph);
    led_level = active ? ph : 1'b1;
  endfunction : led_level

  // full address decode, so higher addresses never alias the low registers
  function automatic logic reg_hit(input logic [31:0] a);
    reg_hit = (a[31:4] == 28'h0);
  endfunction : reg_hit

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.tx_led = led_level(act.tx, phase);
    nxt_st.rx_led = led_level(act.rx, phase);
    nxt_st.col_led = led_level(act.col | (jab & pair_sel), phase);
    nxt_st.link_n = ~link_ok;
    nxt_st.pol_n = (~link_ok) ? 1'b1 : ~(pce & rev);
    nxt_st.jab = jab;
    nxt_st.oe_all = ~standby;
    // pair flags float in aui mode
    nxt_st.oe_pair = ~standby & pair_sel;

    // sticky status: set wins over write-one clear
    nxt_st.prev = ev;
    if (st_ff.dp_write && st_ff.dp_addr == 4'(`LSI_OFF_STATUS))
      nxt_st.status = st_ff.status & ~i_hwdata[`LSI_EV_W-1:0];
    if (st_ff.dp_write && st_ff.dp_addr == 4'(`LSI_OFF_MASK))
      nxt_st.mask = i_hwdata[`LSI_EV_W-1:0];
    if (st_ff.dp_write && st_ff.dp_addr == 4'(`LSI_OFF_CTRL))
      nxt_st.ctrl_en = i_hwdata[0];
    nxt_st.status = nxt_st.status | (ev & ~st_ff.prev);

    // ahb address phase, zero wait states
    nxt_st.dp_write = i_hsel & i_hready & i_htrans[1] & i_hwrite & reg_hit(i_haddr);
    nxt_st.dp_read = i_hsel & i_hready & i_htrans[1] & ~i_hwrite & reg_hit(i_haddr);
    nxt_st.dp_addr = i_haddr[3:0];
    nxt_st.rdata = 32'h0;
    if (i_hsel && i_hready && i_htrans[1] && !i_hwrite && reg_hit(i_haddr))
    begin
      case (i_haddr[3:0])
        4'h0: nxt_st.rdata = {28'h0, nxt_st.status};
        4'h4: nxt_st.rdata = {28'h0, nxt_st.mask};
        4'h8: nxt_st.rdata = {26'h0, standby, pair_sel, jab, rev, link_ok, pce};
        4'hc: nxt_st.rdata = {31'h0, nxt_st.ctrl_en};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      st_ff <= '0;
      st_ff.ctrl_en <= `LSI_CTRL_RST;
      st_ff.tx_led <= 1'b1;
      st_ff.rx_led <= 1'b1;
      st_ff.col_led <= 1'b1;
      st_ff.link_n <= 1'b1;
      st_ff.pol_n <= 1'b1;
    end
    else if (i_ce)
      st_ff <= nxt_st;
  end

  // outputs; ctrl_en gates the pin drivers as a software off switch
  assign o_tx_activity_led_n = st_ff.tx_led;
  assign o_rx_activity_led_n = st_ff.rx_led;
  assign o_collision_led_n = st_ff.col_led;
  assign o_link_good_n = st_ff.link_n;
  assign o_polarity_fault_n = st_ff.pol_n;
  assign o_jabber_flag = st_ff.jab;
  assign o_tx_activity_led_n_oe = st_ff.oe_all & st_ff.ctrl_en;
  assign o_rx_activity_led_n_oe = st_ff.oe_all & st_ff.ctrl_en;
  assign o_collision_led_n_oe = st_ff.oe_all & st_ff.ctrl_en;
  assign o_link_good_n_oe = st_ff.oe_pair & st_ff.ctrl_en;
  assign o_polarity_fault_n_oe = st_ff.oe_pair & st_ff.ctrl_en;
  assign o_jabber_flag_oe = st_ff.oe_pair & st_ff.ctrl_en;
  assign o_polarity_correct_active = pce & rev & pair_sel;
  assign o_irq = |(st_ff.status & st_ff.mask);
  assign o_hrdata = st_ff.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
endmodule : lsi_top
`default_nettype wire

// File: bench/lsi_top_sva.sv
// assertions on the indicator pins of lsi_top
// assumes three edges from pin to output and a flash half period of 4
`default_nettype none
module lsi_top_sva (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_pair_selected,
  input wire logic i_link_ok,
  input wire logic i_pair_rx_reversed,
  input wire logic i_jabber,
  input wire logic i_polarity_correct_enable,
  input wire logic i_ctrl_select_0,
  input wire logic i_ctrl_select_1,
  input wire logic i_ctrl_select_2,
  input wire logic o_tx_activity_led_n,
  input wire logic o_tx_activity_led_n_oe,
  input wire logic o_collision_led_n,
  input wire logic o_collision_led_n_oe,
  input wire logic o_link_good_n,
  input wire logic o_link_good_n_oe,
  input wire logic o_polarity_fault_n,
  input wire logic o_polarity_fault_n_oe,
  input wire logic o_jabber_flag,
  input wire logic o_jabber_flag_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins take three edges to reach the outputs, hence every past depth of 3
  wire logic stby = i_ctrl_select_0 & i_ctrl_select_1 & i_ctrl_select_2;
  wire logic f_oe = o_link_good_n_oe | o_polarity_fault_n_oe | o_jabber_flag_oe;
  wire logic a_oe = f_oe | o_tx_activity_led_n_oe | o_collision_led_n_oe;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  property p_stby; $past(stby, 3) |-> !a_oe; endproperty
  a_stby: assert property (p_stby) else $error("driven in standby");
  property p_aui; !$past(i_pair_selected, 3) |-> !f_oe; endproperty
  a_aui: assert property (p_aui) else $error("flag driven in aui");
  property p_link; o_link_good_n_oe |-> o_link_good_n == !$past(i_link_ok, 3); endproperty
  a_link: assert property (p_link) else $error("link flag");
  property p_pf; o_polarity_fault_n_oe && !$past(i_link_ok, 3) |-> o_polarity_fault_n; endproperty
  a_pf: assert property (p_pf) else $error("fault not forced");
  property p_pol; o_polarity_fault_n_oe && $past(i_link_ok, 3) |-> o_polarity_fault_n ==
    !($past(i_polarity_correct_enable, 3) && $past(i_pair_rx_reversed, 3)); endproperty
  a_pol: assert property (p_pol) else $error("polarity flag");
  property p_jab; o_jabber_flag_oe |-> o_jabber_flag == $past(i_jabber, 3); endproperty
  a_jab: assert property (p_jab) else $error("jabber flag");
  property p_txh; !o_tx_activity_led_n [*4] |=> o_tx_activity_led_n; endproperty
  a_txh: assert property (p_txh) else $error("tx lit too long");
  property p_clh; !o_collision_led_n [*4] |=> o_collision_led_n; endproperty
  a_clh: assert property (p_clh) else $error("col lit too long");
endmodule : lsi_top_sva
bind lsi_top lsi_top_sva sva (.*);
`default_nettype wire

// File: bench/lsi_board.sv
// board side of the indicator pins: led pull-ups and flag monitor
// assumes bits 2:0 are leds and bits 5:3 bare flag lines
`default_nettype none
module lsi_board (
  input wire logic i_clk,
  input wire logic [5:0] i_val,
  input wire logic [5:0] i_oe,
  output logic [5:0] o_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] last_ff;
  // released leds pull high, released flags show their last level inverted
  assign o_pin = i_oe & i_val | ~i_oe & {~last_ff[5:3], 3'h7};
  // last driven level, so a stale flag never reads as valid
  always_ff @(posedge i_clk) last_ff <= i_oe & i_val | ~i_oe & last_ff;
endmodule : lsi_board
`default_nettype wire

// File: bench/lsi_test.sv
// self-checking bench of lsi_top with the board model on its pins
// assumes a flash half period of 4 clocks
`include "lsi_defs.svh"
`default_nettype none
module link_status_indicators_test;
  timeunit 1ns;
  timeprecision 1ns;
  import lsi_pkg::*;
  logic i_clk = 1'h0, i_resetn = 1'h0, i_ce = 1'h1, i_hsel = 1'h0, i_hwrite = 1'h0;
  logic i_pair_selected = 1'h1, i_link_ok = 1'h1, i_pair_rx_reversed = 1'h0, i_jabber = 1'h0;
  logic i_polarity_correct_enable = 1'h0, o_hreadyout, o_hresp, o_polarity_correct_active, o_irq;
  logic [2:0] cs = 3'h0, i_hsize = 3'h2;
  logic [1:0] i_htrans = 2'h0;
  logic [31:0] i_haddr = 32'h0, i_hwdata = 32'h0, o_hrdata, rd;
  lsi_act_t i_pair_act = '0, i_aui_act = '0;
  logic o_tx_activity_led_n, o_rx_activity_led_n, o_collision_led_n, o_link_good_n;
  logic o_polarity_fault_n, o_jabber_flag, o_tx_activity_led_n_oe, o_rx_activity_led_n_oe;
  logic o_collision_led_n_oe, o_link_good_n_oe, o_polarity_fault_n_oe, o_jabber_flag_oe;
  logic [5:0] pin, oe, val;
  wire logic i_hready;
  int fail_count = 0, samples_checked = 0, n[3];
  // the one slave's ready is the bus ready; pins gathered for the board
  assign i_hready = o_hreadyout;
  assign oe = {o_jabber_flag_oe, o_polarity_fault_n_oe, o_link_good_n_oe, o_collision_led_n_oe,
    o_rx_activity_led_n_oe, o_tx_activity_led_n_oe};
  assign val = {o_jabber_flag, o_polarity_fault_n, o_link_good_n, o_collision_led_n,
    o_rx_activity_led_n, o_tx_activity_led_n};
  always #4 i_clk = ~i_clk;
  lsi_top #(.HALF_CYCLES(4)) DUT (.*, .i_ctrl_select_0(cs[0]), .i_ctrl_select_1(cs[1]),
    .i_ctrl_select_2(cs[2]));
  lsi_board board (.i_clk(i_clk), .i_val(val), .i_oe(oe), .o_pin(pin));
  task automatic check(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize
  task wt(input int c);
    repeat (c) @(posedge i_clk);
  endtask : wt
  // bounded wait for ready, so a stuck slave ends the run
  task automatic hwait;
    int k;
    for (k = 0; k < 9; k++)
    begin
      @(posedge i_clk);
      if (o_hreadyout === 1'h1)
        break;
    end
    if (k == 9)
    begin
      fail_count++;
      summarize();
    end
  endtask : hwait
  // one single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [31:0] a, d);
    i_hsel <= 1'h1;
    i_htrans <= 2'h2;
    i_haddr <= a;
    i_hwrite <= w;
    hwait();
    i_hsel <= 1'h0;
    i_htrans <= 2'h0;
    i_hwdata <= d;
    hwait();
    rd = o_hrdata;
    wt(2);
  endtask : xfer
  // count lit led pins over two whole flash periods
  task lit;
    n = '{0, 0, 0};
    repeat (16)
    begin
      @(posedge i_clk);
      for (int i = 0; i < 3; i++)
        n[i] += int'(pin[i] === 1'h0);
    end
  endtask : lit
  // half of each period lit, selected port only
  task t_leds;
    i_pair_act <= 3'h7;
    wt(4);
    lit();
    check(n[0], 8);
    check(n[1], 8);
    check(n[2], 8);
    i_pair_selected <= 1'h0;
    i_aui_act <= 3'h2;
    wt(4);
    lit();
    check(n[0] + n[2], 0);
    check(n[1], 8);
    i_pair_act <= 3'h0;
    i_aui_act <= 3'h0;
    i_pair_selected <= 1'h1;
    wt(4);
  endtask : t_leds
  task t_flags;
    check(pin[3], 1'h0);
    i_pair_rx_reversed <= 1'h1;
    i_polarity_correct_enable <= 1'h1;
    wt(4);
    check(pin[4], 1'h0);
    check(o_polarity_correct_active, 1'h1);
    i_polarity_correct_enable <= 1'h0;
    wt(4);
    check(pin[4], 1'h1);
    check(o_polarity_correct_active, 1'h0);
    i_polarity_correct_enable <= 1'h1;
    i_link_ok <= 1'h0;
    i_jabber <= 1'h1;
    wt(4);
    check(pin[5:3], 3'h7);
    lit();
    check(n[2], 8);
    i_pair_selected <= 1'h0;
    wt(4);
    check(oe[5:3], 3'h0);
    i_pair_selected <= 1'h1;
    i_link_ok <= 1'h1;
    i_jabber <= 1'h0;
    i_pair_rx_reversed <= 1'h0;
    i_polarity_correct_enable <= 1'h0;
    wt(4);
  endtask : t_flags
  // sticky link-loss bit, masked, then cleared by a one
  task t_irq;
    xfer(1'h1, `LSI_OFF_STATUS, 32'hf);
    i_link_ok <= 1'h0;
    wt(4);
    check(o_irq, 1'h0);
    xfer(1'h0, `LSI_OFF_STATUS, 32'h0);
    check(rd, 32'h1);
    check(o_hresp, 1'h0);
    // state register: only pair select stands while the link is down
    xfer(1'h0, `LSI_OFF_STATE, 32'h0);
    check(rd, 32'h10);
    xfer(1'h1, `LSI_OFF_MASK, 32'h1);
    check(o_irq, 1'h1);
    // unmapped read while status is set must not alias status
    xfer(1'h0, 32'h10, 32'h0);
    check(rd, 32'h0);
    xfer(1'h1, `LSI_OFF_STATUS, 32'h1);
    check(o_irq, 1'h0);
    i_link_ok <= 1'h1;
    wt(4);
  endtask : t_irq
  // all selects high float every indicator
  task t_standby;
    cs <= 3'h7;
    wt(4);
    check(oe, 6'h0);
    check(pin[2:0], 3'h7);
    cs <= 3'h0;
    wt(4);
    check(oe[3], 1'h1);
    // software driver switch floats and restores every indicator
    xfer(1'h1, `LSI_OFF_CTRL, 32'h0);
    check(oe, 6'h0);
    xfer(1'h1, `LSI_OFF_CTRL, 32'h1);
    check(oe, 6'h3f);
  endtask : t_standby
  // reset for ten clocks, then each scenario in turn
  initial
  begin
    wt(10);
    i_resetn <= 1'h1;
    wt(4);
    t_leds();
    t_flags();
    t_irq();
    t_standby();
    summarize();
  end
endmodule : link_status_indicators_test
`default_nettype wire
